// File: bench/tb_top.sv
// self-checking bench for the event response delay timer bank
`timescale 1ns/1ps
module tb_top;
  localparam int P = 8;                               // shortened millisecond in cycles
  logic                        i_clk_sys;             // system clock
  logic                        i_resetn;              // async reset, active low
  logic [erdt_pkg::ADDR_W-1:0] i_addr;                // register index
  logic [erdt_pkg::DATA_W-1:0] i_wdata;               // write data
  logic                        i_wr_en;               // write strobe
  logic                        i_rd_en;               // read strobe
  logic [erdt_pkg::DATA_W-1:0] o_rdata;               // read data
  logic [erdt_pkg::NUM_EV-1:0] i_event_cond;          // raw event conditions
  logic [erdt_pkg::NUM_EV-1:0] o_event_fire;          // expiry pulses
  logic [erdt_pkg::NUM_EV-1:0] o_event_active;        // expired levels
  logic                        o_bridge_disable;      // bridge off request
  int                          miscompares;           // mismatch count
  int                          num_checks;            // comparison count

  erdt_top #(.P_MS_CYCLES(P)) i_dut (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rdata(o_rdata), .i_event_cond(i_event_cond),
    .o_event_fire(o_event_fire), .o_event_active(o_event_active), .o_bridge_disable(o_bridge_disable)
  );

  // 40 MHz clock
  always #12.5 i_clk_sys = ~i_clk_sys;

  // compare one value and count it
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one-cycle register write
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge i_clk_sys);
    i_wr_en <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr_en <= 1'b0;
  endtask

  // one-cycle register read, data taken in the following cycle
  task automatic rd(input logic [9:0] a, output logic [15:0] d);
    @(posedge i_clk_sys);
    i_rd_en <= 1'b1;
    i_addr  <= a;
    @(posedge i_clk_sys);
    i_rd_en <= 1'b0;
    #1;
    d = o_rdata;
  endtask

  // wait for a fire pulse on event k, counting cycles
  task automatic wait_fire(input int k, input int lim, output int n);
    n = 0;
    do begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end while (o_event_fire[k] !== 1'b1 && n < lim);
  endtask

  // verdict and end of run
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // watchdog, far beyond the expected run length
  initial begin
    #(25 * 20000);
    miscompares++;
    results();
  end

  // main sequence
  initial begin
    logic [15:0] d;
    int          n;
    int          lo;
    int          hi;
    i_clk_sys = 1'b0;
    i_resetn = 1'b0;
    i_addr = '0;
    i_wdata = '0;
    i_wr_en = 1'b0;
    i_rd_en = 1'b0;
    i_event_cond = '0;
    miscompares = 0;
    num_checks = 0;
    repeat (20) @(posedge i_clk_sys);
    i_resetn <= 1'b1;

    // reset values, readback, status and unmapped places
    for (int k = 0; k < 8; k++) begin
      rd(erdt_pkg::OFF_FIRST + 10'(k), d);
      check("delay reset", d, erdt_pkg::DELAY_RST);
    end
    for (int k = 0; k < 8; k++) wr(erdt_pkg::OFF_FIRST + 10'(k), 16'hff00 ^ 16'(k * 16'h1111));
    for (int k = 0; k < 8; k++) begin
      rd(erdt_pkg::OFF_FIRST + 10'(k), d);
      check("delay readback", d, 16'hff00 ^ 16'(k * 16'h1111));
    end
    @(posedge i_clk_sys);
    #1;
    check("rdata idle", o_rdata, 16'h0000);
    wr(erdt_pkg::OFF_STATUS, 16'hffff);
    rd(erdt_pkg::OFF_STATUS, d);
    check("status", d, 16'h0000);
    wr(10'h000, 16'h1234);
    rd(10'h000, d);
    check("unmapped", d, 16'h0000);
    // write then read the first word with no gap between the strobes
    @(posedge i_clk_sys);
    i_wr_en <= 1'b1;
    i_addr  <= erdt_pkg::OFF_CONT_CUR;
    i_wdata <= 16'h2a5c;
    @(posedge i_clk_sys);
    i_wr_en <= 1'b0;
    i_rd_en <= 1'b1;
    @(posedge i_clk_sys);
    i_rd_en <= 1'b0;
    #1;
    check("back to back", o_rdata, 16'h2a5c);
    $display("test registers done");

    // each event enabled with delay k ms
    for (int k = 0; k < 8; k++) begin
      wr(erdt_pkg::OFF_FIRST + 10'(k), 16'h8000 | 16'(k));
      @(posedge i_clk_sys);
      i_event_cond <= 8'(1 << k);
      wait_fire(k, 200, n);
      lo = (k == 0) ? 4 : 4 + (k - 1) * P;
      hi = (k == 0) ? 4 : 4 + k * P + 1;
      check("fire delay ok", 16'(n >= lo && n <= hi), 16'h0001);
      check("fire vector", 16'(o_event_fire), 16'(1 << k));
      @(posedge i_clk_sys);
      #1;
      check("fire pulse ends", 16'(o_event_fire), 16'h0000);
      check("active", 16'(o_event_active), 16'(1 << k));
      check("bridge", 16'(o_bridge_disable), 16'(k == 5));
      rd(erdt_pkg::OFF_STATUS, d);
      check("status active", d, 16'(1 << k));
      @(posedge i_clk_sys);
      i_event_cond <= '0;
      repeat (3) @(posedge i_clk_sys);
      #1;
      check("active drop", 16'(o_event_active), 16'h0000);
      @(posedge i_clk_sys);
      #1;
      check("bridge drop", 16'(o_bridge_disable), 16'h0000);
    end
    $display("test event delays done");

    // condition drops before expiry: no action
    wr(erdt_pkg::OFF_OVER_V, 16'h8003);
    @(posedge i_clk_sys);
    i_event_cond <= 8'h08;
    repeat (10) @(posedge i_clk_sys);
    i_event_cond <= 8'h00;
    wait_fire(erdt_pkg::EV_OVER_V, 60, n);
    check("early clear fire", 16'(o_event_fire), 16'h0000);
    check("early clear active", 16'(o_event_active), 16'h0000);
    // re-assertion counts the full delay again
    @(posedge i_clk_sys);
    i_event_cond <= 8'h08;
    wait_fire(erdt_pkg::EV_OVER_V, 200, n);
    check("restart delay ok", 16'(n >= 4 + 2 * P && n <= 4 + 3 * P + 1), 16'h0001);
    @(posedge i_clk_sys);
    i_event_cond <= 8'h00;
    $display("test early clear done");

    // enable flag clear: aux disable never reaches the bridge
    wr(erdt_pkg::OFF_AUX_DIS, 16'h0000);
    @(posedge i_clk_sys);
    i_event_cond <= 8'h20;
    wait_fire(erdt_pkg::EV_AUX_DIS, 60, n);
    check("disabled fire", 16'(o_event_fire), 16'h0000);
    check("disabled active", 16'(o_event_active), 16'h0000);
    check("disabled bridge", 16'(o_bridge_disable), 16'h0000);
    rd(erdt_pkg::OFF_STATUS, d);
    check("disabled status", d, 16'h0000);
    // enabling live with zero delay acts at once
    wr(erdt_pkg::OFF_AUX_DIS, 16'h8000);
    repeat (6) @(posedge i_clk_sys);
    #1;
    check("late enable bridge", 16'(o_bridge_disable), 16'h0001);
    // reset in mid-run drops the held action and the delay words
    @(posedge i_clk_sys);
    i_resetn <= 1'b0;
    #1;
    check("reset bridge", 16'(o_bridge_disable), 16'h0000);
    check("reset active", 16'(o_event_active), 16'h0000);
    repeat (3) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    rd(erdt_pkg::OFF_AUX_DIS, d);
    check("reset delay word", d, erdt_pkg::DELAY_RST);
    @(posedge i_clk_sys);
    i_event_cond <= 8'h00;
    repeat (5) @(posedge i_clk_sys);
    $display("test enable flag done");
    results();
  end
endmodule

// File: inc/erdt_pkg.sv
// constants shared by the event response delay timer bank
package erdt_pkg;

  // bank shape
  localparam int NUM_EV = 8;               // number of event timers
  localparam int ADDR_W = 10;              // register index width
  localparam int DATA_W = 16;              // register data width

  // register indices, one word each
  localparam logic [ADDR_W-1:0] OFF_CONT_CUR  = 10'h279;  // continuous_current_delay
  localparam logic [ADDR_W-1:0] OFF_LOOP_SAT  = 10'h27a;  // current_loop_saturated_delay
  localparam logic [ADDR_W-1:0] OFF_UNDER_V   = 10'h27b;  // under_voltage_delay
  localparam logic [ADDR_W-1:0] OFF_OVER_V    = 10'h27c;  // over_voltage_delay
  localparam logic [ADDR_W-1:0] OFF_OVER_SPD  = 10'h27d;  // over_speed_delay
  localparam logic [ADDR_W-1:0] OFF_AUX_DIS   = 10'h27e;  // aux_disable_delay
  localparam logic [ADDR_W-1:0] OFF_SHUNT     = 10'h27f;  // shunt_activity_delay
  localparam logic [ADDR_W-1:0] OFF_CMD_LIM   = 10'h280;  // command_limiter_delay
  localparam logic [ADDR_W-1:0] OFF_STATUS    = 10'h281;  // event_status, read only
  localparam logic [ADDR_W-1:0] OFF_FIRST     = OFF_CONT_CUR;  // base of the delay block

  // event positions in the condition and result vectors
  localparam int EV_CONT_CUR = 0;
  localparam int EV_LOOP_SAT = 1;
  localparam int EV_UNDER_V  = 2;
  localparam int EV_OVER_V   = 3;
  localparam int EV_OVER_SPD = 4;
  localparam int EV_AUX_DIS  = 5;
  localparam int EV_SHUNT    = 6;
  localparam int EV_CMD_LIM  = 7;

  // delay word layout
  localparam int EN_BIT = 15;              // event enable flag
  localparam int DLY_W  = 15;              // millisecond delay field width
  localparam logic [DATA_W-1:0] DELAY_RST = 16'h0000;  // disabled, zero delay

  // status word layout
  localparam int ST_ACTIVE_LSB = 0;        // expired events
  localparam int ST_BUSY_LSB   = 8;        // events counting

  // millisecond tick
  localparam int CLK_PERIOD_NS = 25;       // 40 MHz system clock
  localparam int MS_PERIOD_NS  = 1000000;  // one millisecond
  localparam int MS_CYCLES     = MS_PERIOD_NS / CLK_PERIOD_NS;

  // input synchroniser depth
  localparam int SYNC_STAGES = 2;

endpackage

// File: inc/erdt_tmr_if.sv
// link between the register side and one event delay timer
`timescale 1ns/1ps
interface erdt_tmr_if;
  logic                       tick;    // one-cycle millisecond tick
  logic                       cond;    // synchronised event condition
  logic                       enable;  // event enabled in its delay word
  logic [erdt_pkg::DLY_W-1:0] delay;   // delay in milliseconds
  logic                       fire;    // one-cycle pulse at expiry
  logic                       active;  // expired, condition still present
  logic                       busy;    // counting towards expiry

  modport timer (input tick, input cond, input enable, input delay,
                 output fire, output active, output busy);
  modport ctrl  (output tick, output cond, output enable, output delay,
                 input fire, input active, input busy);
endinterface

// File: src/erdt_timer.sv
// one event response delay timer
`timescale 1ns/1ps
module erdt_timer #(
  parameter int P_DLY_W = erdt_pkg::DLY_W
) (
  input  wire logic i_clk_sys,
  input  wire logic i_resetn,
  erdt_tmr_if.timer tif
);

  // refuse a field width the link cannot carry
  if (P_DLY_W != erdt_pkg::DLY_W) begin : g_chk
    $error("erdt_timer: delay width must match the link");
  end

  logic [P_DLY_W-1:0] cnt_reg;      // elapsed milliseconds
  logic               fire_reg;     // expiry pulse
  logic               active_reg;   // expired and held
  logic               busy_reg;     // counting
  logic               go;           // condition present and enabled
  logic               expire;       // count has reached the delay

  assign go     = tif.cond && tif.enable;
  assign expire = go && busy_reg && !active_reg && (cnt_reg >= tif.delay);

  // millisecond count, restarted whenever the condition drops
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_reg <= '0;
    end else if (!go || !busy_reg) begin
      cnt_reg <= '0;
    end else if (tif.tick && !expire) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // counting flag, set the cycle after the condition is seen
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= go && !(active_reg || expire);
    end
  end

  // expiry pulse and held result; a dropped condition never fires
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      fire_reg   <= 1'b0;
      active_reg <= 1'b0;
    end else begin
      fire_reg   <= expire;
      active_reg <= go && (active_reg || expire);
    end
  end

  assign tif.fire   = fire_reg;
  assign tif.active = active_reg;
  assign tif.busy   = busy_reg;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  fire_one_a: assert property (fire_reg |=> !fire_reg)
    else $error("timer fired twice in a row");
  fire_cause_a: assert property (fire_reg |-> $past(go) && $past(cnt_reg >= tif.delay))
    else $error("timer fired before the delay elapsed");
  clear_noact_a: assert property (!go |=> !active_reg && !fire_reg && !busy_reg)
    else $error("timer acted after its condition cleared");
  expire_now_a: assert property (expire |=> fire_reg && active_reg)
    else $error("timer missed its expiry");
  hold_active_a: assert property (active_reg && go |=> active_reg && !fire_reg)
    else $error("held result lost while condition present");

endmodule

// File: src/erdt_top.sv
// event response delay timer bank with its register port
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps

// Operation
// - continuous current event acts after its delay
// - loop saturation event acts after its delay
// - under-voltage event acts after its delay
// - over-speed event acts after its delay
// - auxiliary disable turns bridge off after delay
// - shunt activity event acts after its delay
// - command limiter event acts after its delay
// - top bit enables event, fifteen-bit delay
module erdt_top #(
  parameter int P_MS_CYCLES = erdt_pkg::MS_CYCLES
) (
  input  wire logic                          i_clk_sys,
  input  wire logic                          i_resetn,
  input  wire logic [erdt_pkg::ADDR_W-1:0]   i_addr,
  input  wire logic [erdt_pkg::DATA_W-1:0]   i_wdata,
  input  wire logic                          i_wr_en,
  input  wire logic                          i_rd_en,
  output wire logic [erdt_pkg::DATA_W-1:0]   o_rdata,
  input  wire logic [erdt_pkg::NUM_EV-1:0]   i_event_cond,
  output wire logic [erdt_pkg::NUM_EV-1:0]   o_event_fire,
  output wire logic [erdt_pkg::NUM_EV-1:0]   o_event_active,
  output wire logic                          o_bridge_disable
);

  localparam int NEV = erdt_pkg::NUM_EV;
  localparam int DW  = erdt_pkg::DATA_W;
  // the prescaler is just wide enough for one millisecond period;
  // TICK_LAST is the final count before it wraps back to zero
  localparam int TW  = (P_MS_CYCLES > 1) ? $clog2(P_MS_CYCLES) : 1;
  localparam logic [TW-1:0] TICK_LAST = TW'(P_MS_CYCLES - 1);

  // refuse a tick period the prescaler cannot serve
  if (P_MS_CYCLES < 2) begin : g_chk
    $error("erdt_top: millisecond period must be at least two cycles");
  end

  // ---------------------------------------------------------------
  // condition synchronisers
  // ---------------------------------------------------------------
  logic [NEV-1:0] cond_s1_reg;   // first stage, read only by the second
  logic [NEV-1:0] cond_s2_reg;   // stable condition levels

  // a condition that changes close to a clock edge may leave the first
  // stage metastable; only the second stage feeds the timers, which
  // costs two cycles of response but keeps every count clean
  // two flops per condition, conditions arrive from outside this clock
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      cond_s1_reg <= '0;
      cond_s2_reg <= '0;
    end else begin
      cond_s1_reg <= i_event_cond;
      cond_s2_reg <= cond_s1_reg;
    end
  end

  // ---------------------------------------------------------------
  // millisecond tick
  // ---------------------------------------------------------------
  logic [TW-1:0] tick_cnt_reg;   // cycles within the current millisecond
  logic          tick_reg;       // one-cycle pulse per millisecond

  // one prescaler for all eight timers keeps them in step; the price is
  // that the first millisecond of a count is partial, so a delay of D
  // acts after D-1 to D milliseconds plus the synchroniser latency
  // free-running prescaler shared by every timer
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
    end else if (tick_cnt_reg == TICK_LAST) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
      tick_reg     <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // delay words and timers, one per event
  // ---------------------------------------------------------------
  logic [NEV-1:0][DW-1:0] delay_w;   // delay words for the read mux
  logic [NEV-1:0]         fire_w;    // expiry pulses
  logic [NEV-1:0]         active_w;  // held results
  logic [NEV-1:0]         busy_w;    // counting flags

  for (genvar g = 0; g < NEV; g++) begin : g_ev
    localparam logic [erdt_pkg::ADDR_W-1:0] MY_OFF =
      erdt_pkg::OFF_FIRST + erdt_pkg::ADDR_W'(g);

    logic [DW-1:0] delay_reg;       // enable flag and millisecond delay
    erdt_tmr_if    tif();           // link to this event's timer

    // writes to the status index or to unmapped indices match no word
    // and are dropped here without any effect
    // software write of the delay word, all sixteen bits kept
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
        delay_reg <= erdt_pkg::DELAY_RST;
      end else if (i_wr_en && (i_addr == MY_OFF)) begin
        delay_reg <= i_wdata;
      end
    end

    // split the word into enable flag and delay field
    assign tif.tick   = tick_reg;
    assign tif.cond   = cond_s2_reg[g];
    assign tif.enable = delay_reg[erdt_pkg::EN_BIT];
    assign tif.delay  = delay_reg[erdt_pkg::DLY_W-1:0];

    // the timer itself: count, expire, hold
    erdt_timer #(
      .P_DLY_W (erdt_pkg::DLY_W)
    ) u_timer (
      .i_clk_sys (i_clk_sys),
      .i_resetn  (i_resetn),
      .tif       (tif.timer)
    );

    assign delay_w[g]  = delay_reg;
    assign fire_w[g]   = tif.fire;
    assign active_w[g] = tif.active;
    assign busy_w[g]   = tif.busy;

    // a fire always traces back to a condition seen three cycles before
    fire_src_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      tif.fire |-> $past(i_event_cond[g], 3) && $past(delay_reg[erdt_pkg::EN_BIT]))
      else $error("event fired without its condition");

    // a disabled event stays silent, whatever its condition does
    dis_quiet_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      !delay_reg[erdt_pkg::EN_BIT] |=> !tif.fire && !tif.active)
      else $error("disabled event acted");

    // the action pulse and the held result start at the same edge
    fire_held_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      tif.fire |-> tif.active)
      else $error("fire without a held result");

    // a timer is either counting or holding its result, never both
    busy_excl_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      !(tif.busy && tif.active))
      else $error("timer counting and expired at once");

    // the synchronised condition rises onto an enabled zero-delay word
    // and both stay for the two cycles the timer needs to expire
    sequence s_arm_now;
      !cond_s2_reg[g] ##1
      (cond_s2_reg[g] && delay_reg[erdt_pkg::EN_BIT] && (delay_reg[erdt_pkg::DLY_W-1:0] == '0)) [*2];
    endsequence

    // with zero delay the action follows the synchronised rise at once
    now_fire_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      s_arm_now |=> tif.fire)
      else $error("zero delay did not act at once");
  end

  // both vectors come straight from timer flops, so the action logic
  // outside sees them with no combinational path in between
  // event results leave straight from the timer flops
  assign o_event_fire   = fire_w;
  assign o_event_active = active_w;

  // ---------------------------------------------------------------
  // power bridge disable
  // ---------------------------------------------------------------
  logic bridge_dis_reg;   // bridge held off while aux disable is active

  // the bridge is released as soon as the aux condition clears; it is
  // not latched, so an input that bounces can turn the bridge off again
  // only after another full delay has run out
  // the auxiliary disable event's action is the bridge turning off
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      bridge_dis_reg <= 1'b0;
    end else begin
      bridge_dis_reg <= active_w[erdt_pkg::EV_AUX_DIS];
    end
  end

  assign o_bridge_disable = bridge_dis_reg;

  // ---------------------------------------------------------------
  // register read port
  // ---------------------------------------------------------------
  logic [DW-1:0] rdata_next;   // selected word for this address
  logic [DW-1:0] rdata_reg;    // read data, valid one cycle after strobe

  // the status word sits just above the delay block; every other index
  // reads zero so that software never sees stale data
  // address decode of the delay block and the status word
  always_comb begin
    rdata_next = '0;  // unmapped addresses read as zero
    if (i_addr == erdt_pkg::OFF_STATUS) begin
      rdata_next[erdt_pkg::ST_ACTIVE_LSB +: NEV] = active_w;
      rdata_next[erdt_pkg::ST_BUSY_LSB +: NEV]   = busy_w;
    end
    for (int i = 0; i < NEV; i++) begin
      if (i_addr == erdt_pkg::OFF_FIRST + erdt_pkg::ADDR_W'(i)) begin
        rdata_next = delay_w[i];
      end
    end
  end

  // clearing the data between reads means a stale word can never be
  // taken for a fresh answer by a master that samples late
  // read data stand only in the cycle after the strobe
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_reg <= '0;
    end else if (i_rd_en) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= '0;
    end
  end

  assign o_rdata = rdata_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // every check below runs on the system clock and is silent in reset;
  // the per-event checks stand in the generate loop beside each timer
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  // write to the first delay word, then read it back
  sequence s_wr_cc;
    i_wr_en && (i_addr == erdt_pkg::OFF_CONT_CUR);
  endsequence

  sequence s_rd_cc;
    i_rd_en && (i_addr == erdt_pkg::OFF_CONT_CUR);
  endsequence

  // the bridge release after aux disable clears
  sequence s_aux_drop;
    active_w[erdt_pkg::EV_AUX_DIS] ##1 !cond_s2_reg[erdt_pkg::EV_AUX_DIS];
  endsequence

  wr_readback_a: assert property (s_wr_cc ##1 s_rd_cc |=> o_rdata == $past(i_wdata, 2))
    else $error("delay word did not read back as written");

  rd_idle_a: assert property (!i_rd_en |=> o_rdata == '0)
    else $error("read data present without a read strobe");

  rd_status_a: assert property (i_rd_en && (i_addr == erdt_pkg::OFF_STATUS)
    |=> o_rdata == {$past(busy_w), $past(active_w)})
    else $error("status word does not show timer state");

  bridge_on_a: assert property (fire_w[erdt_pkg::EV_AUX_DIS] |=> o_bridge_disable)
    else $error("bridge not disabled after aux disable expiry");

  bridge_off_a: assert property (s_aux_drop |-> ##2 !o_bridge_disable)
    else $error("bridge stayed disabled after aux disable cleared");

  bridge_cause_a: assert property ($rose(o_bridge_disable) |-> $past(fire_w[erdt_pkg::EV_AUX_DIS]))
    else $error("bridge disabled without aux disable expiry");

  tick_gap_a: assert property (tick_reg |=> !tick_reg)
    else $error("millisecond tick longer than one cycle");

  // the tick and the prescaler wrap happen at the same edge
  tick_wrap_a: assert property (tick_reg |-> tick_cnt_reg == '0)
    else $error("millisecond tick out of step with its prescaler");

  // the bridge is only off while the aux condition was seen
  bridge_src_a: assert property (o_bridge_disable |-> $past(cond_s2_reg[erdt_pkg::EV_AUX_DIS], 2))
    else $error("bridge disabled without aux disable condition");

  // a read of the first delay word shows the word as it stood
  rd_word_a: assert property (s_rd_cc |=> o_rdata == $past(delay_w[erdt_pkg::EV_CONT_CUR]))
    else $error("delay word read does not match the register");

  // a write to the status index leaves every delay word alone
  wr_ignore_a: assert property (i_wr_en && (i_addr == erdt_pkg::OFF_STATUS) |=> $stable(delay_w))
    else $error("status write changed a delay word");

endmodule
